// File: bench/dual_spi_master_ctrl_status_tb.sv
// Purpose: self-checking bench for the serial master control block
// Assumes: zero-wait apb slave, channel-1 datapath modelled by bench levels
// Notes: random data from a fixed seed, corner cases written by hand
`timescale 1ns/10ps
`default_nettype none
module dual_spi_master_ctrl_status_tb;
    import spim_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, reply, got, d0, d1, ex;
    logic [3:0] pstrb, c1_lv;
    logic sclk, mosi, miso, sel0, sel1, c1_done, c1_permit, c1_en, irq;
    logic [5:0] nbits;
    logic [7:0] n_words;
    logic [3:0] strb_tab [7] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8};
    int bad_count, n_compared, seed, n;

    spim_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clk(sclk), .chan0_data_out(mosi),
        .chan0_data_in(miso), .chan0_select_pin(sel0), .chan1_select_pin(sel1),
        .chan1_block_done(c1_done), .chan1_wr_collide(1'b0), .chan1_rd_collide(1'b0),
        .chan1_wr_fifo_full(c1_lv[0]), .chan1_wr_fifo_empty(c1_lv[1]),
        .chan1_rd_fifo_full(c1_lv[2]), .chan1_rd_fifo_empty(c1_lv[3]),
        .chan1_tx_permit(c1_permit), .chan1_enable(c1_en), .irq(irq));
    spi_slave_model slave (.sclk(sclk), .sel_n(sel0), .mosi(mosi), .miso(miso),
        .nbits(nbits), .reply(reply), .got(got), .n_words(n_words));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // entered just after a rising edge; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            chk(32'h0, 32'h1);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_bit(input int b, input int lim);
        n = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < lim);
        if (n >= lim) begin
            chk(32'h0, 32'h1);
            close_out();
        end
    endtask : wait_bit

    initial begin
        seed = 32'hcaca0573;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, c1_done} = '0;
        c1_lv = 4'(unsigned'($random(seed)));
        nbits = 6'd16;
        reply = $random(seed);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0, 4'h0);
        chk(rd, CTRL_RESET);
        chk({sel0, sel1, irq}, 3'b110);
        ex = (32'h1 << S_WEMPTY) | (32'h1 << S_REMPTY) | (32'(c1_lv[0]) << (S_WFULL + 1))
            | (32'(c1_lv[1]) << (S_WEMPTY + 1)) | (32'(c1_lv[2]) << (S_RFULL + 1))
            | (32'(c1_lv[3]) << (S_REMPTY + 1));
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk(rd, ex);
        apb(1'b0, 8'h10, 32'h0, 4'h0);
        chk(rd, 32'h0);
        // every width code against every access size, selects held high
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, OFF_CTRL, 32'h0000_000d | (32'(w) << C_WIDTH), 4'hf);
            foreach (strb_tab[i]) begin
                apb(1'b1, OFF_BUF0, $random(seed), strb_tab[i]);
                chk(err, !(strb_tab[i] == 4'hf || w == 0
                    || (w == 1 && (strb_tab[i] == 4'h3 || strb_tab[i] == 4'hc))));
            end
        end
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk(rd & 32'h0000_0144, 32'h0000_0044);
        chk(32'(n_words), 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0000_280d, 4'hf);
        chk(irq, 1'b1);
        apb(1'b1, OFF_STATUS, 32'h1 << S_WOVR, 4'hf);
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk({rd[S_WOVR], irq}, 2'b00);
        // second reset in mid-run empties the queues again
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, OFF_CTRL, 32'h0002_0603 | (32'(W_16) << C_WIDTH), 4'hf);
        chk({sel0, sel1, c1_permit, c1_en}, 4'b0011);
        d0 = $random(seed);
        d1 = $random(seed);
        apb(1'b1, OFF_BUF0, d0, 4'hf);
        apb(1'b1, OFF_BUF0, d1, 4'hf);
        wait_bit(S_DONE, 200);
        chk(32'(n_words), 32'h2);
        chk(got, {16'h0, d1[15:0]});
        chk(irq, 1'b1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, OFF_BUF0, 32'h0, 4'h0);
            chk(rd, {16'h0, reply[15:0]});
        end
        apb(1'b1, OFF_STATUS, 32'h0, 4'hf);
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk({rd[S_DONE], rd[S_REMPTY]}, 2'b11);
        apb(1'b1, OFF_STATUS, 32'h1 << S_DONE, 4'hf);
        chk(irq, 1'b0);
        c1_done <= 1'b1;
        @(posedge pclk);
        c1_done <= 1'b0;
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk({rd[S_DONE + 1], irq}, 2'b11);
        apb(1'b1, OFF_STATUS, 32'h1 << (S_DONE + 1), 4'hf);
        // five bytes into a four-deep read queue, guard on the slow rate
        nbits = 6'd8;
        apb(1'b1, OFF_CTRL, 32'h0200_8069, 4'hf);
        repeat (5) apb(1'b1, OFF_BUF0, $random(seed), 4'h1);
        wait_bit(S_ROVR, 300);
        chk({rd[S_RFULL], irq}, 2'b11);
        apb(1'b1, OFF_CTRL, 32'h0200_806c, 4'hf);
        apb(1'b0, OFF_STATUS, 32'h0, 4'h0);
        chk({rd[S_RFULL], rd[S_REMPTY]}, 2'b01);
        close_out();
    end
endmodule : dual_spi_master_ctrl_status_tb
`default_nettype wire

// File: bench/spi_slave_model.sv
// Purpose: serial slave stand-in on channel 0
// Assumes: clock idles low, sample on rise, shift on fall, msb first
// Notes: deselected data line shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
    // pins
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    // word setup and capture
    input wire logic [5:0] nbits,
    input wire logic [31:0] reply,
    output logic [31:0] got,
    output logic [7:0] n_words
);
    logic [5:0] idx;
    logic [31:0] sh;
    initial begin
        idx = 6'h0;
        sh = 32'h0;
        got = 32'h0;
        n_words = 8'h0;
        miso = 1'b0;
    end
    // no pull on the line, so a released line must not look like a held bit
    always @(posedge sel_n) begin
        miso <= ~miso;
    end
    always @(negedge sel_n) begin
        idx = 6'h0;
        miso <= reply[nbits - 6'h1];
    end
    always @(posedge sclk) begin
        if (!sel_n) begin
            sh = (idx == 6'h0) ? {31'h0, mosi} : {sh[30:0], mosi};
            if (idx == nbits - 6'h1) begin
                got <= sh;
                n_words <= n_words + 8'h1;
                idx = 6'h0;
            end else begin
                idx = idx + 6'h1;
            end
        end
    end
    always @(negedge sclk) begin
        if (!sel_n) begin
            miso <= reply[nbits - 6'h1 - idx];
        end
    end
endmodule : spi_slave_model
`default_nettype wire

// File: hdl/spim_ctrl.sv
// Purpose: control, status and channel-0 queues of a two-channel serial master
// Assumes: zero-wait APB slave; channel-1 datapath sits outside and reports here
// Notes: one serial clock is shared; channel 1 only gets its select and permits
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - chan1 pin follows bit, high blocks sending
// - per-channel write-empty interrupt enable
// - per-channel write-overrun interrupt enable
// - per-channel read-overrun interrupt enable
// - done interrupt is enable AND flag
// - cleared enable holds channel in reset
// - guard select picks second rate in variable
// - guard delay of selected clock periods
// - done flag set per block, write-one clears
// - write while full sets write overrun
// - receive while full sets read overrun
// - live write queue full and empty
// - live read queue full and empty
// - four-entry write queue, full drops writes
// - disable flushes the read queue
// - start needs enable, low select, data, selector
// - sixteen-bit width uses low half only
// - four-entry read queue takes received words
// - wide widths need word access
// - sixteen-bit width refuses byte access
// - eight-bit width accepts every size
// - width codes three to zero mean 32..8
// - block is one to four transfers
// - variable clock enable selects mode
module spim_ctrl
    import spim_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    output logic serial_clk,
    output logic chan0_data_out,
    input wire logic chan0_data_in,
    output logic chan0_select_pin,
    output logic chan1_select_pin,
    // channel-1 datapath reports and permits
    input wire logic chan1_block_done,
    input wire logic chan1_wr_collide,
    input wire logic chan1_rd_collide,
    input wire logic chan1_wr_fifo_full,
    input wire logic chan1_wr_fifo_empty,
    input wire logic chan1_rd_fifo_full,
    input wire logic chan1_rd_fifo_empty,
    output logic chan1_tx_permit,
    output logic chan1_enable,
    // interrupt
    output logic irq
);
    logic [31:0] ctrl;
    logic [1:0] done_flag;
    logic [1:0] wr_ovr_flag;
    logic [1:0] rd_ovr_flag;
    logic [1:0] blk_cnt;
    logic [7:0] guard_left;
    logic [3:0] tick_cnt;
    xfer_state_e state;
    xfer_state_e next_state;

    // control fields
    wire chan0_enable = ctrl[C_CH0_EN];
    wire chan0_select_bit = ctrl[C_CH0_SEL];
    wire chan1_select_bit = ctrl[C_CH1_SEL];
    wire start_channel_select = ctrl[C_STC];
    wire variable_clock_enable = ctrl[C_VARCLK];
    wire guard_clock_select = ctrl[C_GCS];
    wire [1:0] transfer_width_code = ctrl[C_WIDTH +: 2];
    wire [1:0] done_ie = ctrl[C_DONE_IE +: 2];
    wire [1:0] wr_empty_ie = ctrl[C_WEMPTY_IE +: 2];
    wire [1:0] wr_ovr_ie = ctrl[C_WOVR_IE +: 2];
    wire [1:0] rd_ovr_ie = ctrl[C_ROVR_IE +: 2];
    wire [1:0] chan0_block_count = ctrl[C_BLK0 +: 2];
    wire [6:0] guard_delay_count = ctrl[C_GUARD +: 7];

    // bus decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire sel_ctrl = (paddr == OFF_CTRL);
    wire sel_stat = (paddr == OFF_STATUS);
    wire sel_buf = (paddr == OFF_BUF0);
    wire strb_word = (pstrb == 4'hf);
    wire strb_half = (pstrb == 4'h3) || (pstrb == 4'hc);
    wire strb_byte = (pstrb == 4'h1) || (pstrb == 4'h2) || (pstrb == 4'h4) || (pstrb == 4'h8);
    wire size_ok = strb_word || (strb_half && transfer_width_code <= W_16)
        || (strb_byte && transfer_width_code == W_8);
    wire buf_err = access && pwrite && sel_buf && !size_ok;
    wire wr_ctrl = access && pwrite && sel_ctrl;
    wire wr_stat = access && pwrite && sel_stat;
    wire wr_buf = access && pwrite && sel_buf && size_ok;
    wire rd_buf = access && !pwrite && sel_buf;
    wire [4:0] lane_shift = pstrb[0] ? 5'd0 : pstrb[1] ? 5'd8 : pstrb[2] ? 5'd16 : 5'd24;
    wire [31:0] lane_mask = strb_word ? 32'hffff_ffff : strb_half ? 32'h0000_ffff : 32'h0000_00ff;
    wire [31:0] buf_wdata = (pwdata >> lane_shift) & lane_mask;

    assign pready = 1'b1;
    assign pslverr = buf_err;

    // queues and engine
    logic [31:0] tx_head;
    logic [31:0] rx_head;
    logic [31:0] rx_word;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic busy;
    logic xfer_done;
    wire [3:0] xfer_half = 4'(FIRST_HALF_CYC);
    wire [3:0] guard_half = (variable_clock_enable && guard_clock_select) ?
        4'(SECOND_HALF_CYC) : 4'(FIRST_HALF_CYC);
    wire start = (state == ST_IDLE) && chan0_enable && !chan0_select_bit
        && !tx_empty && !start_channel_select;
    wire [5:0] nbits = width_bits(transfer_width_code);
    // low half kept for 16 bits
    wire [63:0] width_mask = (64'h1 << nbits) - 64'h1;
    wire [31:0] rx_masked = rx_word & width_mask[31:0];
    wire rx_push = xfer_done && chan0_enable;
    wire blk_end = rx_push && (blk_cnt == chan0_block_count);

    spim_fifo u_txq (
        .pclk(pclk),
        .presetn(presetn),
        .flush(1'b0),
        .push(wr_buf),
        .push_data(buf_wdata),
        .pop(start),
        .head(tx_head),
        .full(tx_full),
        .empty(tx_empty)
    );

    spim_fifo u_rxq (
        .pclk(pclk),
        .presetn(presetn),
        .flush(!chan0_enable),
        .push(rx_push),
        .push_data(rx_masked),
        .pop(rd_buf),
        .head(rx_head),
        .full(rx_full),
        .empty(rx_empty)
    );

    spim_shifter u_shift (
        .pclk(pclk),
        .presetn(presetn),
        .clear(!chan0_enable),
        .start(start),
        .tx_word(tx_head),
        .nbits(nbits),
        .half_cyc(xfer_half),
        .busy(busy),
        .done(xfer_done),
        .rx_word(rx_word),
        .sclk(serial_clk),
        .mosi(chan0_data_out),
        .miso(chan0_data_in)
    );

    assign chan0_select_pin = chan0_select_bit;
    assign chan1_select_pin = chan1_select_bit;
    assign chan1_tx_permit = chan1_enable && !chan1_select_bit;
    assign chan1_enable = ctrl[C_CH1_EN];

    wire [31:0] status = 32'(
        {!chan1_rd_fifo_empty ? 1'b0 : 1'b1, rx_empty,
         chan1_rd_fifo_full, rx_full,
         chan1_wr_fifo_empty, tx_empty,
         chan1_wr_fifo_full, tx_full,
         rd_ovr_flag, wr_ovr_flag, done_flag});

    assign irq = |(done_flag & done_ie) || |(wr_ovr_flag & wr_ovr_ie)
        || |(rd_ovr_flag & rd_ovr_ie)
        || |({chan1_wr_fifo_empty, tx_empty} & wr_empty_ie);

    // read data is caught in the setup cycle so the zero-wait access sees it
    wire [31:0] rd_mux = sel_ctrl ? ctrl : sel_stat ? status : sel_buf ? rx_head : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= pwdata & CTRL_MASK;
        end
    end

    // write-one clear, a new set wins
    wire [1:0] done_set = {chan1_block_done, blk_end};
    wire [1:0] wovr_set = {chan1_wr_collide, wr_buf && tx_full};
    wire [1:0] rovr_set = {chan1_rd_collide, rx_push && rx_full};
    wire [1:0] clr_done = wr_stat ? pwdata[S_DONE +: 2] : 2'h0;
    wire [1:0] clr_wovr = wr_stat ? pwdata[S_WOVR +: 2] : 2'h0;
    wire [1:0] clr_rovr = wr_stat ? pwdata[S_ROVR +: 2] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 2'h0;
            wr_ovr_flag <= 2'h0;
            rd_ovr_flag <= 2'h0;
        end else begin
            done_flag <= done_set | (done_flag & ~clr_done);
            wr_ovr_flag <= wovr_set | (wr_ovr_flag & ~clr_wovr);
            rd_ovr_flag <= rovr_set | (rd_ovr_flag & ~clr_rovr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_cnt <= 2'h0;
        end else if (!chan0_enable || blk_end) begin
            blk_cnt <= 2'h0;
        end else if (rx_push) begin
            blk_cnt <= blk_cnt + 2'h1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = start ? ST_SHIFT : ST_IDLE;
            ST_SHIFT: begin
                if (xfer_done) begin
                    next_state = (guard_delay_count != 7'h0) ? ST_GUARD : ST_IDLE;
                end
            end
            ST_GUARD: begin
                if (guard_left == 8'h0) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (!chan0_enable) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // guard counts half periods: two per selected serial clock cycle
    wire tick = (tick_cnt == guard_half - 4'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard_left <= 8'h0;
            tick_cnt <= 4'h0;
        end else if (state != ST_GUARD) begin
            guard_left <= {guard_delay_count, 1'b0};
            tick_cnt <= 4'h0;
        end else begin
            tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;
            if (tick && guard_left != 8'h0) begin
                guard_left <= guard_left - 8'h1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_gate: assert property (start |-> !chan0_select_pin && chan0_enable
        && !tx_empty && !start_channel_select)
        else $error("transfer began without its preconditions");
    a_done_irq_now: assert property ((done_flag[0] && done_ie[0]) |-> irq)
        else $error("done interrupt missing");
    a_wovr_on_full: assert property ((wr_buf && tx_full) |=> wr_ovr_flag[0]
        && tx_full)
        else $error("write overrun not flagged or queue changed");
    a_rovr_on_full: assert property ((rx_push && rx_full && !rd_buf) |=> rd_ovr_flag[0])
        else $error("read overrun not flagged");
    a_disable_flush: assert property (!chan0_enable |=> rx_empty && !busy)
        else $error("disabled channel kept data or ran");
    a_guard_gap: assert property ((xfer_done && guard_delay_count != 7'h0
        && chan0_enable) |=> !start [*8])
        else $error("next word went out inside guard time");
    a_byte_refused: assert property ((access && pwrite && sel_buf && strb_byte
        && transfer_width_code != W_8) |-> pslverr ##1 $stable(tx_empty))
        else $error("byte access to buffer not refused");
    a_done_w1c: assert property ((wr_stat && pwdata[S_DONE] && !done_set[0])
        |=> !done_flag[0])
        else $error("done flag not cleared by write one");
    a_word_only: assert property ((access && sel_buf && pwrite && strb_half
        && transfer_width_code > W_16) |-> pslverr)
        else $error("half access accepted at wide width");

    c_transfer: cover property (start ##[1:400] xfer_done);
    c_guard: cover property (state == ST_GUARD ##1 state == ST_IDLE);
    c_wr_overrun: cover property (wr_buf && tx_full);
    c_size_error: cover property (buf_err);
endmodule : spim_ctrl
`default_nettype wire

// File: hdl/spim_fifo.sv
// Purpose: four-entry word queue with flush
// Assumes: push when full and pop when empty are ignored
// Notes: head word is shown without a pop
`timescale 1ns/10ps
`default_nettype none
module spim_fifo
    import spim_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic [31:0] push_data,
    input wire logic pop,
    // state
    output logic [31:0] head,
    output logic full,
    output logic empty
);
    logic [31:0] mem [FIFO_DEPTH];
    logic [1:0] rd_ptr;
    logic [1:0] wr_ptr;
    logic [2:0] count;
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign full = (count == 3'(FIFO_DEPTH));
    assign empty = (count == 3'h0);
    assign head = mem[rd_ptr];

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
            count <= 3'h0;
        end else if (flush) begin
            rd_ptr <= 2'h0;
            wr_ptr <= 2'h0;
            count <= 3'h0;
        end else begin
            wr_ptr <= wr_ptr + 2'(do_push);
            rd_ptr <= rd_ptr + 2'(do_pop);
            count <= count + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule : spim_fifo
`default_nettype wire

// File: hdl/spim_pkg.sv
// Purpose: shared constants for the two-channel serial master control block
// Assumes: 25 MHz bus clock, 32-bit APB data
// Notes: field positions of control and status words live here
package spim_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FIRST_RATE_PERIOD_NS = 320;
    localparam int SECOND_RATE_PERIOD_NS = 640;
    localparam int FIRST_HALF_CYC = FIRST_RATE_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int SECOND_HALF_CYC = SECOND_RATE_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 4;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_BUF0 = 8'h08;
    // control word fields
    localparam int C_CH0_EN = 0;
    localparam int C_CH1_EN = 1;
    localparam int C_CH0_SEL = 2;
    localparam int C_CH1_SEL = 3;
    localparam int C_STC = 4;
    localparam int C_VARCLK = 5;
    localparam int C_GCS = 6;
    localparam int C_WIDTH = 7;
    localparam int C_DONE_IE = 9;
    localparam int C_WEMPTY_IE = 11;
    localparam int C_WOVR_IE = 13;
    localparam int C_ROVR_IE = 15;
    localparam int C_BLK0 = 17;
    localparam int C_BLK1 = 19;
    localparam int C_GUARD = 24;
    localparam logic [31:0] CTRL_RESET = 32'h0000_000c;
    localparam logic [31:0] CTRL_MASK = 32'h7f1f_ffff;
    // status word fields, pairs are channel 0 then channel 1
    localparam int S_DONE = 0;
    localparam int S_WOVR = 2;
    localparam int S_ROVR = 4;
    localparam int S_WFULL = 6;
    localparam int S_WEMPTY = 8;
    localparam int S_RFULL = 10;
    localparam int S_REMPTY = 12;
    // transfer width codes
    localparam logic [1:0] W_8 = 2'h0;
    localparam logic [1:0] W_16 = 2'h1;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_GUARD = 2'h3
    } xfer_state_e;

    function automatic logic [5:0] width_bits(input logic [1:0] code);
        width_bits = {3'(code) + 3'h1, 3'h0};
    endfunction : width_bits
endpackage : spim_pkg

// File: hdl/spim_shifter.sv
// Purpose: serial shift engine, clock idles low, msb first
// Assumes: data-in pin is asynchronous to pclk
// Notes: received word is zero extended above the active width
`timescale 1ns/10ps
`default_nettype none
module spim_shifter
    import spim_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clear,
    input wire logic start,
    input wire logic [31:0] tx_word,
    input wire logic [5:0] nbits,
    input wire logic [3:0] half_cyc,
    // results
    output logic busy,
    output logic done,
    output logic [31:0] rx_word,
    // pins
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    logic [2:0] sync;
    logic miso_s;
    logic [31:0] shreg;
    logic [3:0] half_cnt;
    logic [5:0] bits_left;
    wire half_end = (half_cnt == half_cyc - 4'h1);
    // the held copy lags the agreeing stages by a clock, too late for the rising sample
    wire miso_now = (sync[1] == sync[2]) ? sync[2] : miso_s;

    assign mosi = shreg[31];

    // a pin level counts only once the second and third stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync <= 3'h0;
            miso_s <= 1'b0;
        end else begin
            sync <= {sync[1:0], miso};
            miso_s <= miso_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            sclk <= 1'b0;
            shreg <= 32'h0;
            rx_word <= 32'h0;
            half_cnt <= 4'h0;
            bits_left <= 6'h0;
        end else if (clear) begin
            busy <= 1'b0;
            done <= 1'b0;
            sclk <= 1'b0;
            shreg <= 32'h0;
            half_cnt <= 4'h0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                shreg <= tx_word << (6'd32 - nbits);
                rx_word <= 32'h0;
                bits_left <= nbits;
                half_cnt <= 4'h0;
            end else if (busy) begin
                half_cnt <= half_end ? 4'h0 : half_cnt + 4'h1;
                if (half_end) begin
                    sclk <= !sclk;
                    if (!sclk) begin
                        rx_word <= {rx_word[30:0], miso_now};
                    end else begin
                        shreg <= shreg << 1;
                        bits_left <= bits_left - 6'h1;
                        if (bits_left == 6'h1) begin
                            busy <= 1'b0;
                            done <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule : spim_shifter
`default_nettype wire
